// File: logic/sts_pkg.sv
`default_nettype none
package sts_pkg;

  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int RA_W    = 5;
  localparam int CTRL_W  = 14;
  localparam int HOLD_W  = 16;

  // register byte offsets
  localparam logic [RA_W-1:0] REG_CTRL    = 5'h00;
  localparam logic [RA_W-1:0] REG_HOLDOFF = 5'h04;
  localparam logic [RA_W-1:0] REG_PRETRIG = 5'h08;
  localparam logic [RA_W-1:0] REG_ARM     = 5'h0C;
  localparam logic [RA_W-1:0] REG_STATUS  = 5'h10;

  // control register bit positions
  localparam int CB_STORE  = 0;
  localparam int CB_PEAK   = 1;
  localparam int CB_NORM   = 2;
  localparam int CB_SLOW   = 3;
  localparam int CB_SLOPE  = 4;
  localparam int CB_INT    = 5;
  localparam int CB_SRC    = 7;
  localparam int CB_ALT    = 9;
  localparam int CB_CHOPPED_DISPLAY   = 10;
  localparam int CB_INV2   = 11;
  localparam int CB_SAVE   = 12;
  localparam int CB_SINGLE = 13;
  localparam int CB_ARM    = 0;

  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST    = 14'h0000;
  localparam logic [HOLD_W-1:0] HOLDOFF_RST = 16'h0010;
  localparam logic [ADDR_W-1:0] PRETRIG_RST = 12'h800;

  // auto trigger: no adequate trigger within one period of 20 Hz
  localparam int AUTO_PERIOD_NS = 50_000_000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int AUTO_CYCLES    =
    (AUTO_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] INT_CH1    = 2'h0;
  localparam logic [1:0] INT_FOLLOW = 2'h1;
  localparam logic [1:0] INT_CH2    = 2'h2;
  localparam logic [1:0] SRC_INT    = 2'h0;
  localparam logic [1:0] SRC_LINE   = 2'h1;
  localparam logic [1:0] SRC_EXT    = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_ARMED = 3'b010,
    ST_POST  = 3'b011,
    ST_COPY  = 3'b100,
    ST_DONE  = 3'b101,
    ST_ROLL  = 3'b110,
    ST_LIVE  = 3'b111
  } sts_state_e;

  typedef enum logic [2:0] {
    SM_LIVE     = 3'b000,
    SM_SCAN     = 3'b001,
    SM_ROLL     = 3'b010,
    SM_ROLLSTOP = 3'b011,
    SM_RECORD   = 3'b100
  } sts_smode_e;

endpackage
`default_nettype wire

// File: logic/sts_trigger_sequencer.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - frozen acquisition ignores trigger controls until the next one.
// - store normal keeps display, refills pretrigger until trigger.
// - slow normal scans: copy pretrigger at trigger, then append samples.
// - fast modes fill post-trigger memory before updating the whole display.
// - slow peak-auto store disables triggering and rolls freely.
// - fast peak-auto generates an auto trigger when no trigger comes.
// - roll ignores triggers; newest sample written at rightmost position.
// - peak-auto plus normal selects field sync, otherwise acts as peak-auto.
// - single shot arms one acquisition; rearming needs another press.
// - single arm starts acquisition; ready stays off until pretrigger full.
// - after single trigger, post samples complete record; ready clears.
// - slow single erases display, rolls through trigger, freezes when full.
// - fast single keeps old waveform, then replaces the whole record.
// - indicator shows trigger in auto/normal, armed-and-waiting in single.
// - mark trigger position and separator between new and old data.
// - slope select picks rising or falling crossing of trigger signal.
// - follow source alternates channels in alternate mode, sums in chopped.
// - source selector routes internal, power line or external trigger.
// - store holdoff spans record transfer and pretrigger refill.
// - stored trigger also waits for live holdoff to finish.
// - live holdoff starts at sweep end and blocks new sweeps.
// - channel two inversion also inverts its internal trigger.
// - leaving freeze restarts acquisition; trigger waits for refill.
module sts_trigger_sequencer #(
  parameter int ADDR_W      = sts_pkg::ADDR_W,
  parameter int AUTO_CYCLES = sts_pkg::AUTO_CYCLES
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic [sts_pkg::RA_W-1:0]    regAddr,
  input  wire logic [sts_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output var  logic [sts_pkg::DATA_W-1:0]  regRdData,
  input  wire logic                        sampleTick,
  input  wire logic                        sweepEnd,
  input  wire logic                        trigChOne,
  input  wire logic                        trigChTwo,
  input  wire logic                        trigSum,
  input  wire logic                        trigLine,
  input  wire logic                        trigExt,
  output var  logic                        acqWrEn,
  output var  logic [ADDR_W-1:0]           acqAddr,
  output var  logic                        dispWrEn,
  output var  logic                        dispFromAcq,
  output var  logic [ADDR_W-1:0]           dispAddr,
  output var  logic [ADDR_W-1:0]           dispSrcAddr,
  output var  logic                        rollShift,
  output var  logic                        dispErase,
  output var  logic                        trigMark,
  output var  logic [ADDR_W-1:0]           trigAddr,
  output var  logic                        sepMark,
  output var  logic [ADDR_W-1:0]           sepAddr,
  output var  logic                        sweepStart,
  output var  logic                        indicatorLed,
  output var  logic                        fieldSync,
  output var  logic [2:0]                  storageMode,
  output var  logic                        holdoffActive
);
  import sts_pkg::*;

  localparam logic [ADDR_W-1:0] REC_LAST = '1;

  logic [CTRL_W-1:0] ctrl;
  logic [HOLD_W-1:0] holdReg;
  logic [ADDR_W-1:0] pretrigReg;
  logic [CTRL_W-1:0] cCtrl;
  logic [HOLD_W-1:0] cHold;
  logic [ADDR_W-1:0] cPre;
  sts_state_e        state;
  sts_smode_e        curMode;
  sts_smode_e        newMode;
  logic [4:0]        syncA;
  logic [4:0]        syncB;
  logic              selSig;
  logic              selPrev;
  logic              trigHit;
  logic              altPick;
  logic [HOLD_W-1:0] holdCnt;
  logic              holdBusy;
  logic [31:0]       autoCnt;
  logic              autoEn;
  logic              autoFire;
  logic              armPend;
  logic              saveQ;
  logic              frozen;
  logic              unfreeze;
  logic              startAcq;
  logic              accept;
  logic              liveFire;
  logic              sweeping;
  logic              afterCopyPost;
  logic [ADDR_W-1:0] wrPtr;
  logic [ADDR_W-1:0] fillCnt;
  logic [ADDR_W-1:0] postCnt;
  logic [ADDR_W-1:0] lastPost;
  logic [ADDR_W-1:0] copyCnt;
  logic [ADDR_W-1:0] copyLast;
  logic [ADDR_W-1:0] copyBase;
  logic              acquiring;
  logic              rolling;

  function automatic sts_smode_e smodeOf(input logic [CTRL_W-1:0] c);
    if (!c[CB_STORE])
      return SM_LIVE;
    else if (!c[CB_SLOW])
      return SM_RECORD;
    else if (c[CB_SINGLE])
      return SM_ROLLSTOP;
    // peak-auto alone or with normal (field sync) rolls when slow
    else if (c[CB_PEAK])
      return SM_ROLL;
    else
      return SM_SCAN;
  endfunction

  // register port, read data one cycle after the strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl       <= CTRL_RST;
      holdReg    <= HOLDOFF_RST;
      pretrigReg <= PRETRIG_RST;
    end else if (regWrite) begin
      unique case (regAddr)
        REG_CTRL:    ctrl       <= regWrData[CTRL_W-1:0];
        REG_HOLDOFF: holdReg    <= regWrData[HOLD_W-1:0];
        REG_PRETRIG: pretrigReg <= regWrData[ADDR_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead) begin
      unique case (regAddr)
        REG_CTRL:    regRdData <= DATA_W'(ctrl);
        REG_HOLDOFF: regRdData <= DATA_W'(holdReg);
        REG_PRETRIG: regRdData <= DATA_W'(pretrigReg);
        REG_STATUS:  regRdData <= DATA_W'({holdoffActive, armPend, holdBusy,
                                   indicatorLed, storageMode, state});
        default:     regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // comparator pins come from the analog side, two flops first
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA   <= 5'h00;
      syncB   <= 5'h00;
      selPrev <= 1'b0;
    end else begin
      syncA   <= {trigExt, trigLine, trigSum, trigChTwo, trigChOne};
      syncB   <= syncA;
      selPrev <= selSig;
    end
  end

  always_comb begin
    logic chTwo;
    logic intSig;
    intSig = syncB[0];
    chTwo  = syncB[1] ^ cCtrl[CB_INV2];
    unique case (cCtrl[CB_INT +: 2])
      INT_CH2:    intSig = chTwo;
      INT_FOLLOW: intSig = cCtrl[CB_CHOPPED_DISPLAY] ? syncB[2] :
                           (cCtrl[CB_ALT] && altPick) ? chTwo : syncB[0];
      default:    intSig = syncB[0];
    endcase
    unique case (cCtrl[CB_SRC +: 2])
      SRC_LINE: selSig = syncB[3];
      SRC_EXT:  selSig = syncB[4];
      default:  selSig = intSig;
    endcase
  end

  assign trigHit = cCtrl[CB_SLOPE] ? (selPrev && !selSig)
                                   : (!selPrev && selSig);

  assign frozen   = ctrl[CB_STORE] && ctrl[CB_SAVE];
  assign unfreeze = ctrl[CB_STORE] && saveQ && !ctrl[CB_SAVE];
  assign newMode  = smodeOf(ctrl);
  assign curMode  = sts_smode_e'(storageMode);
  // single waits for an arm press
  assign startAcq = ctrl[CB_STORE] && !frozen && (unfreeze ||
                    (state == ST_IDLE && (!ctrl[CB_SINGLE] || armPend)) ||
                    (state == ST_DONE && armPend));
  // stored trigger also waits for live holdoff
  assign accept   = state == ST_ARMED && !frozen && !holdBusy &&
                    (trigHit || autoFire);
  assign liveFire = state == ST_LIVE && !sweeping && !holdBusy &&
                    (trigHit || autoFire) &&
                    (!cCtrl[CB_SINGLE] || armPend);
  assign holdBusy = holdCnt != '0;
  assign lastPost = REC_LAST - cPre;
  assign acquiring = !frozen && (state == ST_PRE || state == ST_ARMED ||
                     state == ST_POST || state == ST_ROLL);
  assign rolling  = curMode == SM_ROLL ||
                    (curMode == SM_ROLLSTOP && state != ST_DONE);

  // trigger controls reach the logic every cycle in live, and in store only at acquisition start
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cCtrl       <= CTRL_RST;
      cHold       <= HOLDOFF_RST;
      cPre        <= PRETRIG_RST;
      storageMode <= SM_LIVE;
      fieldSync   <= 1'b0;
      saveQ       <= 1'b0;
    end else begin
      saveQ <= ctrl[CB_SAVE];
      if (!ctrl[CB_STORE] || startAcq) begin
        cCtrl       <= ctrl;
        cHold       <= holdReg;
        cPre        <= pretrigReg;
        storageMode <= newMode;
        // both mode inputs select field sync
        fieldSync   <= ctrl[CB_PEAK] && ctrl[CB_NORM];
      end
    end
  end

  // live holdoff from each sweep end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdCnt <= '0;
    end else if (sweepEnd) begin
      holdCnt <= cHold;
    end else if (holdBusy) begin
      holdCnt <= holdCnt - 1'b1;
    end
  end

  // auto trigger when peak-auto sees no adequate trigger
  assign autoEn   = cCtrl[CB_PEAK] && !cCtrl[CB_SINGLE] && !holdBusy &&
                    ((state == ST_LIVE && !sweeping) ||
                     (state == ST_ARMED && !frozen));
  assign autoFire = autoEn && autoCnt == 32'(AUTO_CYCLES - 1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      autoCnt <= 32'h0000_0000;
    end else if (!autoEn || trigHit || autoFire) begin
      autoCnt <= 32'h0000_0000;
    end else begin
      autoCnt <= autoCnt + 1'b1;
    end
  end

  // arm is set by a press; the press wins over consumption
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armPend <= 1'b0;
    end else if (regWrite && regAddr == REG_ARM && regWrData[CB_ARM]) begin
      armPend <= 1'b1;
    end else if ((startAcq && state != ST_PRE && state != ST_ARMED &&
                  state != ST_POST && state != ST_COPY &&
                  state != ST_ROLL) || (liveFire && cCtrl[CB_SINGLE])) begin
      armPend <= 1'b0;
    end
  end

  // live sweep and alternate channel pick
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sweeping   <= 1'b0;
      sweepStart <= 1'b0;
      altPick    <= 1'b0;
    end else begin
      sweepStart <= liveFire;
      if (liveFire)
        sweeping <= 1'b1;
      else if (sweepEnd)
        sweeping <= 1'b0;
      // alternate source per sweep or acquisition
      if ((liveFire || startAcq) && cCtrl[CB_ALT])
        altPick <= !altPick;
    end
  end

  // ready only once pretrigger is full
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      indicatorLed  <= 1'b0;
      holdoffActive <= 1'b0;
    end else begin
      if (cCtrl[CB_SINGLE])
        indicatorLed <= cCtrl[CB_STORE] ? state == ST_ARMED : armPend;
      else if (accept || liveFire)
        indicatorLed <= trigHit;
      // store holdoff covers transfer and refill
      holdoffActive <= holdBusy || state == ST_PRE ||
                       (state == ST_COPY && !afterCopyPost);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= ST_IDLE;
      wrPtr         <= '0;
      fillCnt       <= '0;
      postCnt       <= '0;
      copyCnt       <= '0;
      copyLast      <= '0;
      copyBase      <= '0;
      afterCopyPost <= 1'b0;
      acqWrEn       <= 1'b0;
      acqAddr       <= '0;
      dispWrEn      <= 1'b0;
      dispFromAcq   <= 1'b0;
      dispAddr      <= '0;
      dispSrcAddr   <= '0;
      rollShift     <= 1'b0;
      dispErase     <= 1'b0;
      trigMark      <= 1'b0;
      trigAddr      <= '0;
      sepMark       <= 1'b0;
      sepAddr       <= '0;
    end else begin
      acqWrEn     <= 1'b0;
      dispWrEn    <= 1'b0;
      dispFromAcq <= 1'b0;
      rollShift   <= 1'b0;
      dispErase   <= 1'b0;
      trigMark    <= 1'b0;
      sepMark     <= 1'b0;
      // memory keeps taking samples until the post fill completes, and without end in roll
      if (acquiring && sampleTick) begin
        acqWrEn <= 1'b1;
        acqAddr <= wrPtr;
        wrPtr   <= wrPtr + 1'b1;
        if (rolling) begin
          dispWrEn  <= 1'b1;
          dispAddr  <= REC_LAST;
          rollShift <= 1'b1;
        end
      end
      if (!ctrl[CB_STORE]) begin
        state <= ST_LIVE;
      end else if (startAcq) begin
        // slow peak-auto runs free in roll
        state   <= newMode == SM_ROLL ? ST_ROLL : ST_PRE;
        fillCnt <= '0;
        // slow single erases the old waveform
        dispErase <= newMode == SM_ROLLSTOP;
      end else if (!frozen) begin
        unique case (state)
          ST_LIVE: state <= ST_IDLE;
          ST_PRE: begin
            // trigger waits for a full pretrigger region
            if (cPre == '0)
              state <= ST_ARMED;
            else if (sampleTick) begin
              fillCnt <= fillCnt + 1'b1;
              if (fillCnt == cPre - 1'b1)
                state <= ST_ARMED;
            end
          end
          ST_ARMED: begin
            if (accept) begin
              trigMark <= 1'b1;
              trigAddr <= wrPtr;
              postCnt  <= '0;
              if (curMode == SM_SCAN && cPre != '0) begin
                copyBase      <= wrPtr - cPre;
                copyCnt       <= '0;
                copyLast      <= cPre - 1'b1;
                afterCopyPost <= 1'b1;
                state         <= ST_COPY;
              end else begin
                state <= ST_POST;
              end
            end
          end
          ST_POST: begin
            if (sampleTick) begin
              postCnt <= postCnt + 1'b1;
              if (curMode == SM_SCAN) begin
                dispWrEn <= 1'b1;
                dispAddr <= cPre + postCnt;
                sepMark  <= 1'b1;
                sepAddr  <= cPre + postCnt + 1'b1;
              end
              if (postCnt == lastPost) begin
                // whole record goes to display after post fill
                // fast single replaces the record at once
                if (curMode == SM_RECORD) begin
                  copyBase      <= wrPtr + 1'b1;
                  copyCnt       <= '0;
                  copyLast      <= REC_LAST;
                  afterCopyPost <= 1'b0;
                  state         <= ST_COPY;
                end else begin
                  // single completes, then waits for rearm
                  state   <= cCtrl[CB_SINGLE] ? ST_DONE : ST_PRE;
                  fillCnt <= '0;
                end
              end
            end
          end
          ST_COPY: begin
            dispWrEn    <= 1'b1;
            dispFromAcq <= 1'b1;
            dispAddr    <= copyCnt;
            dispSrcAddr <= copyBase + copyCnt;
            copyCnt     <= copyCnt + 1'b1;
            if (copyCnt == copyLast) begin
              sepMark <= 1'b1;
              sepAddr <= copyCnt + 1'b1;
              fillCnt <= '0;
              if (afterCopyPost)
                state <= ST_POST;
              else
                state <= cCtrl[CB_SINGLE] ? ST_DONE : ST_PRE;
            end
          end
          ST_IDLE, ST_DONE, ST_ROLL: ;
        endcase
      end
    end
  end

  property p_frozen_hold;
    @(posedge core_clk) disable iff (sys_rst)
      frozen && $past(frozen) |-> $stable(state);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold)
    else $error("state moved while frozen");

  property p_pre_overwrite;
    @(posedge core_clk) disable iff (sys_rst)
      state == ST_ARMED && sampleTick && !frozen |=> acqWrEn;
  endproperty
  a_pre_overwrite: assert property (p_pre_overwrite)
    else $error("armed sample not written");

  property p_scan_copy;
    @(posedge core_clk) disable iff (sys_rst)
      accept && !startAcq && ctrl[CB_STORE] && curMode == SM_SCAN &&
      cPre != '0
      |=> state == ST_COPY && trigMark;
  endproperty
  a_scan_copy: assert property (p_scan_copy)
    else $error("scan trigger did not refresh pretrigger");

  property p_record_no_update;
    @(posedge core_clk) disable iff (sys_rst)
      state == ST_POST && curMode == SM_RECORD |=> !dispWrEn;
  endproperty
  a_record_no_update: assert property (p_record_no_update)
    else $error("display written during record post fill");

  property p_roll_write;
    @(posedge core_clk) disable iff (sys_rst)
      state == ST_ROLL && sampleTick && !frozen && ctrl[CB_STORE]
      |=> dispWrEn && rollShift && dispAddr == REC_LAST && !trigMark;
  endproperty
  a_roll_write: assert property (p_roll_write)
    else $error("roll sample not at right edge");

  property p_auto_fire;
    @(posedge core_clk) disable iff (sys_rst)
      autoFire && accept && !startAcq && ctrl[CB_STORE] |=> trigMark;
  endproperty
  a_auto_fire: assert property (p_auto_fire)
    else $error("auto trigger not taken");

  property p_ready_off;
    @(posedge core_clk) disable iff (sys_rst)
      state == ST_PRE && cCtrl[CB_SINGLE] && cCtrl[CB_STORE]
      |=> !indicatorLed;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("ready lit before pretrigger full");

  sequence s_single_end;
    state == ST_POST && cCtrl[CB_SINGLE] && ctrl[CB_STORE] && !startAcq
    ##1 state == ST_DONE;
  endsequence

  property p_single_end;
    @(posedge core_clk) disable iff (sys_rst)
      s_single_end |=> !indicatorLed;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("ready still lit after single completes");

  property p_single_once;
    @(posedge core_clk) disable iff (sys_rst)
      state == ST_DONE && !armPend && ctrl[CB_STORE] && !unfreeze
      |=> state == ST_DONE;
  endproperty
  a_single_once: assert property (p_single_once)
    else $error("single shot rearmed without press");

  property p_store_holdoff;
    @(posedge core_clk) disable iff (sys_rst)
      state == ST_ARMED && holdBusy |=> !trigMark;
  endproperty
  a_store_holdoff: assert property (p_store_holdoff)
    else $error("trigger taken during live holdoff");

  property p_live_holdoff;
    @(posedge core_clk) disable iff (sys_rst)
      sweepEnd && cHold != '0 |=> holdBusy ##1 !sweepStart;
  endproperty
  a_live_holdoff: assert property (p_live_holdoff)
    else $error("sweep started inside holdoff");

endmodule // sts_trigger_sequencer
`default_nettype wire

// File: sim/sts_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
module sts_panel_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       trigLevel,
  input  wire logic       sweepStart,
  output wire logic       sampleTick,
  output wire logic       sweepEnd,
  output wire logic [4:0] trigIn
);
  logic tickR, endR;
  logic [2:0] swCnt;
  // masked by reset so nothing is unknown before the first edge
  assign sampleTick = tickR & ~sys_rst;
  assign sweepEnd = endR & ~sys_rst;
  // channel two comparator sees the inverse level
  assign trigIn = {{3{trigLevel}}, ~trigLevel, trigLevel};
  // a sample every other cycle; a sweep lasts five cycles
  always @(posedge core_clk) begin
    tickR <= ~tickR & ~sys_rst;
    endR <= swCnt == 3'h1;
    swCnt <= sys_rst ? 3'h0 : sweepStart ? 3'h5 : swCnt - 3'(swCnt != 3'h0);
  end
endmodule // sts_panel_model
`default_nettype wire

// File: sim/sts_trigger_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sts_trigger_sequencer_tb_top;
  import sts_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic trigLevel = 1'b0, sawHold = 1'b0;
  logic [RA_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData, got;
  logic [4:0] trigIn;
  logic [2:0] storageMode;
  logic sampleTick, sweepEnd, sweepStart, trigMark, sepMark;
  logic holdoffActive, indicatorLed, fieldSync;
  int errors = 0, comparisons = 0, nStart = 0, nMark = 0, nSep = 0, k;
  int mdl [int];
  int ctl [4] = '{4'hD, 4'hB, 4'h5, 4'h7};
  int src [5] = '{12'h000, 12'h840, 12'h050, 12'h100, 12'h420};
  sts_smode_e md [4] = '{SM_SCAN, SM_ROLL, SM_RECORD, SM_RECORD};
  sts_trigger_sequencer #(.AUTO_CYCLES(20)) sts_trigger_sequencer_inst (
    .core_clk, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .sampleTick, .sweepEnd, .trigChOne(trigIn[0]),
    .trigChTwo(trigIn[1]), .trigSum(trigIn[2]), .trigLine(trigIn[3]),
    .trigExt(trigIn[4]), .acqWrEn(), .acqAddr(), .dispWrEn(),
    .dispFromAcq(), .dispAddr(), .dispSrcAddr(), .rollShift(),
    .dispErase(), .trigMark, .trigAddr(), .sepMark, .sepAddr(),
    .sweepStart, .indicatorLed, .fieldSync, .storageMode, .holdoffActive);
  sts_panel_model sts_panel_model_inst (.core_clk, .sys_rst, .trigLevel,
    .sweepStart, .sampleTick, .sweepEnd, .trigIn);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    nStart += sweepStart;
    nMark += trigMark;
    nSep += sepMark;
    sawHold |= holdoffActive === 1'b1;
  end
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [RA_W-1:0] a, input int d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    if (a == REG_CTRL) mdl[a] = d & 32'h0000_3FFF;
    if (a == REG_HOLDOFF) mdl[a] = d & 32'h0000_FFFF;
    if (a == REG_PRETRIG) mdl[a] = d & 32'h0000_0FFF;
    cyc(1);
    regWrite <= 1'b0;
    cyc(1);
  endtask
  // read data is taken in the one cycle it stands
  task automatic rd(input logic [RA_W-1:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    cyc(1);
    regRead <= 1'b0;
    cyc(1);
    got = regRdData;
  endtask
  task automatic acquire(input logic single);
    int m;
    got = '0;
    for (int i = 0; i < 300 && got[2:0] !== 3'h2; i++) rd(REG_STATUS);
    check(got[2:0], 3'h2); // armed after refill
    if (single) check(indicatorLed, 1'b1); // ready once armed
    m = nMark;
    trigLevel <= 1'b1;
    sawHold = 1'b0;
    cyc(20);
    check(nMark - m, 1); // one trigger mark
    if (!single) check(indicatorLed, 1'b1); // lamp on trigger
    trigLevel <= 1'b0;
    m = nSep;
    for (int i = 0; i < 20000 && nSep == m; i++) cyc(1);
    check(nSep - m, 1); // record then separator
    check(sawHold, 1'b1); // store holdoff seen
    if (single) check(indicatorLed, 1'b0); // dark when done
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #600_000;
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(83));
    mdl[REG_CTRL] = 0;
    mdl[REG_HOLDOFF] = 32'h0000_0010;
    mdl[REG_PRETRIG] = 32'h0000_0800;
    mdl[5'h14] = 0;
    cyc(12);
    sys_rst <= 1'b0;
    cyc(1);
    foreach (mdl[a]) begin
      rd(5'(a));
      check(got, mdl[a]); // reset values, unmapped zero
    end
    wr(REG_PRETRIG, $urandom);
    rd(REG_PRETRIG);
    check(got, mdl[REG_PRETRIG]); // field width
    $display("test registers done");
    wr(REG_HOLDOFF, 8);
    foreach (src[i]) begin
      wr(REG_CTRL, src[i]);
      cyc(20);
      k = nStart;
      trigLevel <= 1'b1;
      cyc(30);
      check(nStart - k, 1); // sweep on the edge
      trigLevel <= 1'b0;
      cyc(30);
      check(nStart - k, 1); // one sweep per rising edge
    end
    check(sawHold, 1'b1); // holdoff after sweep
    wr(REG_CTRL, 2);
    k = nStart;
    cyc(100);
    check(nStart > k, 1); // auto trigger free runs
    check(indicatorLed, 1'b0); // dark on auto trigger
    $display("test live done");
    for (k = 0; k < 4; k++) begin
      wr(REG_CTRL, 0);
      cyc(4);
      wr(REG_CTRL, ctl[k]);
      cyc(8);
      check(storageMode, md[k]); // storage mode choice
      check(fieldSync, k == 3); // field sync choice
    end
    $display("test modes done");
    wr(REG_CTRL, 0);
    wr(REG_PRETRIG, 2);
    wr(REG_CTRL, 5);
    acquire(1'b0);
    acquire(1'b0);
    cyc(10);
    wr(REG_CTRL, 14'h1005);
    k = nMark;
    trigLevel <= 1'b1;
    cyc(20);
    check(nMark - k, 0); // frozen ignores triggers
    trigLevel <= 1'b0;
    wr(REG_CTRL, 5);
    rd(REG_STATUS);
    check(got[2:0], 3'h1); // refill before trigger
    wr(REG_CTRL, 0);
    wr(REG_CTRL, 14'h2005);
    wr(REG_ARM, 1);
    acquire(1'b1);
    k = nMark;
    trigLevel <= 1'b1;
    cyc(20);
    trigLevel <= 1'b0;
    rd(REG_STATUS);
    check(nMark - k, 0); // no second shot without press
    check(got[2:0], 3'h5); // done until rearmed
    $display("test store done");
    complete_run();
  end
endmodule // sts_trigger_sequencer_tb_top
`default_nettype wire
